// [eis_asserts.sv]
// Port assertions for the interrupt input switch
`timescale 1ns/1ps
`default_nettype none
module eis_asserts (
  input wire logic pclk, input wire logic presetn, input wire logic forced_stop_req,
  input wire logic irq_a_pulse, input wire logic irq_b_pulse, input wire logic stop_release_req,
  input wire logic timer_restart_a, input wire logic timer_restart_b);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_route_a: assert property (!(irq_a_pulse && timer_restart_a))
    else $error("input A on two routes");
  a_route_b: assert property (!(irq_b_pulse && timer_restart_b))
    else $error("input B on two routes");
  a_release_cause: assert property (stop_release_req |-> irq_a_pulse || irq_b_pulse)
    else $error("stop release without interrupt edge");
  a_forced_level: assert property (timer_restart_a |-> forced_stop_req)
    else $error("restart on A without forced stop");
endmodule
bind eis_switch eis_asserts i_eis_asserts (.pclk(pclk), .presetn(presetn),
  .forced_stop_req(forced_stop_req), .irq_a_pulse(irq_a_pulse), .irq_b_pulse(irq_b_pulse),
  .stop_release_req(stop_release_req), .timer_restart_a(timer_restart_a),
  .timer_restart_b(timer_restart_b));
`default_nettype wire

// [eis_pins.sv]
// Behavioural model of the two external interrupt pins
`timescale 1ns/1ps
`default_nettype none
module eis_pins (input wire logic pclk, output logic pin_a, output logic pin_b);
  initial {pin_a, pin_b} = 2'b00;
  task set_pins(input logic a, input logic b);
    @(posedge pclk);
    {pin_a, pin_b} <= {a, b};
  endtask
endmodule
`default_nettype wire

// [eis_pkg.sv]
// Package for the external interrupt input switch: offsets, fields, reset values
package eis_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] SEL_OFFSET = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;
  localparam logic [11:0] PIN_STATE_OFFSET = 12'h00C;

  // ==========================================================
  // Select register fields
  localparam int A_RESTART_BIT = 0;
  localparam int B_RESTART_BIT = 1;
  localparam int A_FILTER_OFF_BIT = 2;
  localparam int B_FILTER_OFF_BIT = 3;
  localparam int A_INVERT_BIT = 4;
  localparam int B_INVERT_BIT = 5;
  localparam logic [7:0] SEL_RESET = 8'h03;
  localparam logic [7:0] SEL_WRITE_MASK = 8'h3F;

  // ==========================================================
  // Status bits: interrupt edges and restart edges per input
  localparam int ST_A_IRQ_BIT = 0;
  localparam int ST_B_IRQ_BIT = 1;
  localparam int ST_A_RST_BIT = 2;
  localparam int ST_B_RST_BIT = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // ==========================================================
  // Noise filter: input must be stable this many cycles
  localparam int FILTER_NS = 12;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FILTER_LAST = 2'(FILTER_CYCLES - 1);

  typedef struct packed {
    logic invert;
    logic filter_off;
    logic restart_route;
  } eis_chan_cfg_type;

  typedef struct packed {
    logic irq_edge;
    logic restart_edge;
    logic stop_release;
    logic forced_stop;
  } eis_chan_out_type;

endpackage

// [eis_switch.sv]
// External interrupt input conditioning, routing and APB register file
// How it works
// - Invert bit set inverts input before use
// - Filter bit zero enables noise filter
// - Input B route: interrupt or timer restart
// - Input A route: interrupt or restart/forced stop
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module eis_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_input_a,
  input wire logic ext_irq_input_b,
  output logic irq_a_pulse,
  output logic irq_b_pulse,
  output logic stop_release_req,
  output logic timer_restart_a,
  output logic timer_restart_b,
  output logic forced_stop_req,
  output logic irq
);

  // ==========================================================
  // Register file
  logic [7:0] sel_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic access;
  logic wr;
  logic [3:0] events;
  logic [1:0] cond;
  logic [1:0] cond_d_reg;
  logic [1:0] edge_det;
  eis_pkg::eis_chan_cfg_type cfg [2];

  assign access = psel && penable;
  // Write lands only at the edge that completes the access phase
  assign wr = access && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= eis_pkg::SEL_RESET;
    end else if (wr && paddr == eis_pkg::SEL_OFFSET) begin
      sel_reg <= pwdata[7:0] & eis_pkg::SEL_WRITE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= eis_pkg::MASK_RESET;
    end else if (wr && paddr == eis_pkg::IRQ_MASK_OFFSET) begin
      mask_reg <= pwdata[3:0];
    end
  end

  // Set wins over write-one-to-clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= eis_pkg::STATUS_RESET;
    end else if (wr && paddr == eis_pkg::IRQ_STATUS_OFFSET) begin
      status_reg <= (status_reg & ~pwdata[3:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !pready) begin
        case (paddr)
          eis_pkg::SEL_OFFSET: prdata <= {24'h000000, sel_reg};
          eis_pkg::IRQ_STATUS_OFFSET: prdata <= {28'h0000000, status_reg};
          eis_pkg::IRQ_MASK_OFFSET: prdata <= {28'h0000000, mask_reg};
          eis_pkg::PIN_STATE_OFFSET: prdata <= {30'h0, cond};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_reg | events) & mask_reg);
    end
  end

  // ==========================================================
  // Per-input conditioning
  assign cfg[0] = '{invert: sel_reg[eis_pkg::A_INVERT_BIT],
                    filter_off: sel_reg[eis_pkg::A_FILTER_OFF_BIT],
                    restart_route: sel_reg[eis_pkg::A_RESTART_BIT]};
  assign cfg[1] = '{invert: sel_reg[eis_pkg::B_INVERT_BIT],
                    filter_off: sel_reg[eis_pkg::B_FILTER_OFF_BIT],
                    restart_route: sel_reg[eis_pkg::B_RESTART_BIT]};

  logic [1:0] raw;
  assign raw = {ext_irq_input_b, ext_irq_input_a};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic pol;
      logic filt_reg;
      logic [1:0] cnt_reg;
      assign pol = raw[g] ^ cfg[g].invert;
      // Filter holds last stable level until input stays put for the window
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_reg <= 1'b0;
          cnt_reg <= 2'b00;
        end else if (pol == filt_reg) begin
          cnt_reg <= 2'b00;
        end else if (cnt_reg == eis_pkg::FILTER_LAST) begin
          filt_reg <= pol;
          cnt_reg <= 2'b00;
        end else begin
          cnt_reg <= cnt_reg + 2'b01;
        end
      end
      assign cond[g] = cfg[g].filter_off ? pol : filt_reg;
    end
  endgenerate

  // Rising edge of the conditioned signal is the event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_d_reg <= 2'b00;
    end else begin
      cond_d_reg <= cond;
    end
  end
  assign edge_det = cond & ~cond_d_reg;

  // ==========================================================
  // Routing
  eis_pkg::eis_chan_out_type route_a;
  eis_pkg::eis_chan_out_type route_b;

  always_comb begin
    route_a.irq_edge = edge_det[0] && !cfg[0].restart_route;
    route_a.restart_edge = edge_det[0] && cfg[0].restart_route;
    route_a.stop_release = route_a.irq_edge;
    route_a.forced_stop = cond[0] && cfg[0].restart_route;
    route_b.irq_edge = edge_det[1] && !cfg[1].restart_route;
    route_b.restart_edge = edge_det[1] && cfg[1].restart_route;
    route_b.stop_release = route_b.irq_edge;
    route_b.forced_stop = 1'b0;
  end

  assign events = {route_b.restart_edge, route_a.restart_edge,
                   route_b.irq_edge, route_a.irq_edge};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_pulse <= 1'b0;
      irq_b_pulse <= 1'b0;
      stop_release_req <= 1'b0;
      timer_restart_a <= 1'b0;
      timer_restart_b <= 1'b0;
      forced_stop_req <= 1'b0;
    end else begin
      irq_a_pulse <= route_a.irq_edge;
      irq_b_pulse <= route_b.irq_edge;
      stop_release_req <= route_a.stop_release || route_b.stop_release;
      timer_restart_a <= route_a.restart_edge;
      timer_restart_b <= route_b.restart_edge;
      // Level, held while the conditioned input A is active on restart route
      forced_stop_req <= route_a.forced_stop;
    end
  end

endmodule

`default_nettype wire

// [tb_ext_irq_input_switch.sv]
// Self-checking bench for the interrupt input switch
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_ext_irq_input_switch;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, irq, err, pin_a, pin_b, irq_a_pulse, irq_b_pulse, stop_release_req;
  logic timer_restart_a, timer_restart_b, forced_stop_req;
  logic [4:0] seen = 5'h00;
  int failures = 0, checks = 0;
  eis_switch i_eis_switch (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_irq_input_a(pin_a), .ext_irq_input_b(pin_b), .irq_a_pulse,
    .irq_b_pulse, .stop_release_req, .timer_restart_a, .timer_restart_b, .forced_stop_req, .irq);
  eis_pins i_eis_pins (.pclk, .pin_a, .pin_b);
  // Sticky record, so a one-cycle pulse cannot slip between checks
  always @(posedge pclk) seen <= seen | {stop_release_req, timer_restart_b, timer_restart_a,
    irq_b_pulse, irq_a_pulse};
  initial forever #2 pclk = ~pclk;
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Pready, prdata and pslverr are read as they stood before this edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    {err, rdat} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task prep(input logic [7:0] s);
    apb(1'b1, eis_pkg::SEL_OFFSET, {24'h0, s});
    i_eis_pins.set_pins(1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    apb(1'b1, eis_pkg::IRQ_STATUS_OFFSET, 32'hF);
    @(negedge pclk) seen = 5'h00;
  endtask
  task pins(input logic a, input logic b, input logic [4:0] e);
    i_eis_pins.set_pins(a, b);
    repeat (10) @(posedge pclk);
    `CHK(seen, e)
  endtask
  task t_routes;
    apb(1'b0, eis_pkg::SEL_OFFSET, 32'h0);
    `CHK({err, rdat}, 33'h3)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, rdat}, 33'h100000000)
    prep(8'h0C);
    pins(1'b1, 1'b1, 5'h13);
    `CHK(irq, 1'b0)
    apb(1'b1, eis_pkg::IRQ_MASK_OFFSET, 32'h1);
    apb(1'b0, eis_pkg::IRQ_STATUS_OFFSET, 32'h0);
    `CHK({irq, rdat}, 33'h100000003)
    apb(1'b1, eis_pkg::IRQ_STATUS_OFFSET, 32'h1);
    apb(1'b0, eis_pkg::IRQ_STATUS_OFFSET, 32'h0);
    `CHK({irq, rdat}, 33'h2)
    prep(8'h0F);
    pins(1'b1, 1'b1, 5'h0C);
    `CHK(forced_stop_req, 1'b1)
    apb(1'b0, eis_pkg::IRQ_STATUS_OFFSET, 32'h0);
    `CHK({irq, rdat}, 33'hC)
    apb(1'b0, eis_pkg::PIN_STATE_OFFSET, 32'h0);
    `CHK({err, rdat}, 33'h3)
    $display("t_routes done");
  endtask
  task t_cond;
    prep(8'h14);
    pins(1'b1, 1'b0, 5'h00);
    i_eis_pins.set_pins(1'b0, 1'b1);
    pins(1'b1, 1'b0, 5'h11);
    $display("t_cond done");
  endtask
  task wrap_up;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_routes;
    t_cond;
    wrap_up;
  end
  initial begin
    #40000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
